// ===== src/mqf_pkg.sv
// Purpose: Shared constants and types for the queue strap and flag-bus ends.
// Assumes: One clock serves as both write and read clock.
// Notes:   Widths, FIFO depth, marker bits, masks, default offsets and bus reset values are named here.
`default_nettype none

package mqf_pkg;

  // ---------------------------------------------------------------------------
  // Widths and FIFO depth
  // ---------------------------------------------------------------------------
  localparam int DATA_W     = 36;
  localparam int FLAG_W     = 4;
  localparam int ADDR_W     = 3;
  localparam int OFFS_W     = 8;
  localparam int FIFO_DEPTH = 8;

  // ---------------------------------------------------------------------------
  // Packet marker bit positions and bus-width masks
  // ---------------------------------------------------------------------------
  localparam int MARK_SOP_BIT = 34;
  localparam int MARK_EOP_BIT = 35;

  localparam logic [DATA_W-1:0] MASK_X36 = 36'hF_FFFF_FFFF;
  localparam logic [DATA_W-1:0] MASK_X18 = 36'h0_0003_FFFF;
  localparam logic [DATA_W-1:0] MASK_X9  = 36'h0_0000_01FF;

  // ---------------------------------------------------------------------------
  // Default offsets and reset values
  // ---------------------------------------------------------------------------
  localparam logic [OFFS_W-1:0] OFFSET_LOW  = 8'h08;
  localparam logic [OFFS_W-1:0] OFFSET_HIGH = 8'h80;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET  = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 3'h0;

  // ---------------------------------------------------------------------------
  // Device configuration sequence
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STRAP   = 2'b00,
    ST_PROGRAM = 2'b01,
    ST_RUN     = 2'b10
  } mqf_cfg_state_type;

endpackage

`default_nettype wire

// ===== src/mqf_link_if.sv
// Purpose: Pins between the host controller and one multi-queue device.
// Assumes: Single clock; bus resolution is done by whoever joins the ends.
// Notes:   The flag bus is a three-state output given as data plus enable.
`default_nettype none

interface mqf_link_if;
  import mqf_pkg::*;

  logic                width_match_strap;
  logic                input_width_strap;
  logic                output_width_strap;
  logic                default_offset_strap;
  logic                program_method_strap;
  logic                flag_bus_mode_strap;
  logic [DATA_W-1:0]   data_in;
  logic                write_en_n;
  logic                full_n;
  logic                ae_bus_strobe;
  logic [ADDR_W-1:0]   read_address_bus;
  logic [FLAG_W-1:0]   almost_empty_bus;
  logic                almost_empty_bus_oe_n;
  logic                ae_bus_sync;
  logic                expansion_token_in;
  logic                expansion_token_out;
  logic                serial_program_done_n;

  modport device (
    input  width_match_strap,
    input  input_width_strap,
    input  output_width_strap,
    input  default_offset_strap,
    input  program_method_strap,
    input  flag_bus_mode_strap,
    input  data_in,
    input  write_en_n,
    output full_n,
    input  ae_bus_strobe,
    input  read_address_bus,
    output almost_empty_bus,
    output almost_empty_bus_oe_n,
    output ae_bus_sync,
    input  expansion_token_in,
    output expansion_token_out,
    output serial_program_done_n
  );

  modport host (
    output width_match_strap,
    output input_width_strap,
    output output_width_strap,
    output default_offset_strap,
    output program_method_strap,
    output flag_bus_mode_strap,
    output data_in,
    output write_en_n,
    input  full_n,
    output ae_bus_strobe,
    output read_address_bus,
    input  almost_empty_bus,
    input  almost_empty_bus_oe_n,
    input  ae_bus_sync,
    output expansion_token_in,
    input  expansion_token_out,
    input  serial_program_done_n
  );

endinterface

`default_nettype wire

// ===== src/mqf_device_end.sv
// Purpose: Device end: reset straps, write capture and almost-empty flag bus.
// Assumes: REF_CLK is both write and read clock; straps held by the host.
// Notes:   Write data passes through an 8-word FIFO to the user side.
`default_nettype none

module mqf_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  almost_full
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] CNT_FULL  = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ALMST = CNT_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_LAST  = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             push;
  logic             pop;

  assign in_ready    = (count_reg != CNT_FULL);
  assign out_valid   = (count_reg != '0);
  assign almost_full = (count_reg >= CNT_ALMST);
  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;
  assign out_data    = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module mqf_device_end (
  input  wire logic                        REF_CLK,
  input  wire logic                        RST_N,
  mqf_link_if.device                       LINK,
  input  wire logic [mqf_pkg::FLAG_W-1:0]  USR_AE_STATUS,
  input  wire logic [mqf_pkg::ADDR_W-1:0]  USR_DEV_ADDR,
  input  wire logic                        USR_CHAIN_FIRST,
  input  wire logic                        USR_PACKET_MODE,
  input  wire logic                        USR_SERIAL_DONE,
  output logic      [mqf_pkg::DATA_W-1:0]  USR_DATA,
  output logic                             USR_SOP,
  output logic                             USR_EOP,
  output logic                             USR_VALID,
  input  wire logic                        USR_READY,
  output logic      [mqf_pkg::OFFS_W-1:0]  USR_AE_OFFSET,
  output logic      [mqf_pkg::OFFS_W-1:0]  USR_AF_OFFSET,
  output logic                             USR_POLLED,
  output logic      [2:0]                  USR_WIDTH_CFG,
  output logic                             USR_RUN
);
  import mqf_pkg::*;

  // ---------------------------------------------------------------------------
  // Strap capture and programming sequence
  // ---------------------------------------------------------------------------
  mqf_cfg_state_type state_reg;
  logic              polled_reg;
  logic              method_default_reg;
  logic [2:0]        width_reg;
  logic [OFFS_W-1:0] offset_reg;
  logic              done_n_reg;
  logic              start_reg;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_STRAP;
    end else begin
      unique case (state_reg)
        ST_STRAP:   state_reg <= ST_PROGRAM;
        ST_PROGRAM: if (method_default_reg || USR_SERIAL_DONE) begin
          state_reg <= ST_RUN;
        end
        ST_RUN:     state_reg <= ST_RUN;
        default:    state_reg <= ST_STRAP;
      endcase
    end
  end

  // Straps are sampled once, on the first edge after reset release.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      polled_reg         <= 1'b0;
      method_default_reg <= 1'b0;
      width_reg          <= 3'h0;
      offset_reg         <= OFFSET_LOW;
    end else if (state_reg == ST_STRAP) begin
      polled_reg         <= LINK.flag_bus_mode_strap;
      method_default_reg <= LINK.program_method_strap;
      width_reg          <= {LINK.width_match_strap, LINK.input_width_strap, LINK.output_width_strap};
      if (LINK.program_method_strap) begin
        offset_reg <= LINK.default_offset_strap ? OFFSET_HIGH : OFFSET_LOW;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_n_reg <= 1'b1;
      start_reg  <= 1'b0;
    end else begin
      done_n_reg <= (state_reg != ST_RUN);
      // The chain head launches the first token once programming is over.
      start_reg  <= (state_reg == ST_PROGRAM) && (method_default_reg || USR_SERIAL_DONE)
                    && polled_reg && USR_CHAIN_FIRST;
    end
  end

  assign LINK.serial_program_done_n = done_n_reg;
  assign USR_AE_OFFSET = offset_reg;
  assign USR_AF_OFFSET = offset_reg;
  assign USR_POLLED    = polled_reg;
  assign USR_WIDTH_CFG = width_reg;
  assign USR_RUN       = !done_n_reg;

  // ---------------------------------------------------------------------------
  // Write capture into the FIFO
  // ---------------------------------------------------------------------------
  logic              fifo_in_valid;
  logic              fifo_almost_full;
  logic [DATA_W-1:0] fifo_out_data;

  assign fifo_in_valid = !LINK.write_en_n;
  // One slot is kept free for the write already in flight from the host.
  assign LINK.full_n   = !fifo_almost_full;

  mqf_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk         (REF_CLK),
    .rst_n       (RST_N),
    .in_valid    (fifo_in_valid),
    .in_ready    (),
    .in_data     (LINK.data_in),
    .out_valid   (USR_VALID),
    .out_ready   (USR_READY),
    .out_data    (fifo_out_data),
    .almost_full (fifo_almost_full)
  );

  assign USR_DATA = fifo_out_data;
  assign USR_SOP  = USR_PACKET_MODE && fifo_out_data[MARK_SOP_BIT];
  assign USR_EOP  = USR_PACKET_MODE && fifo_out_data[MARK_EOP_BIT];

  // ---------------------------------------------------------------------------
  // Almost-empty flag bus
  // ---------------------------------------------------------------------------
  logic              selected_reg;
  logic              token_drive_reg;
  logic [FLAG_W-1:0] ae_data_reg;
  logic              run;

  assign run = (state_reg == ST_RUN);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      selected_reg <= 1'b0;
    end else if (run && !polled_reg && LINK.ae_bus_strobe) begin
      selected_reg <= (LINK.read_address_bus == USR_DEV_ADDR);
    end
  end

  // One cycle of drive per token; the bus is released once the token moves on.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      token_drive_reg <= 1'b0;
    end else begin
      token_drive_reg <= polled_reg && (start_reg || (run && LINK.expansion_token_in));
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ae_data_reg <= FLAGS_RESET;
    end else begin
      ae_data_reg <= USR_AE_STATUS;
    end
  end

  assign LINK.almost_empty_bus      = ae_data_reg;
  assign LINK.almost_empty_bus_oe_n = polled_reg ? !token_drive_reg : !selected_reg;
  assign LINK.expansion_token_out   = token_drive_reg;
  assign LINK.ae_bus_sync           = token_drive_reg && USR_CHAIN_FIRST;

endmodule

`default_nettype wire

// ===== src/mqf_host_end.sv
// Purpose: Host end: straps, data writes, flag-bus selection and token wiring.
// Assumes: Strap inputs are held steady by the user from before reset on.
// Notes:   Flag-bus samples are presented with a valid while a device drives.
`default_nettype none

module mqf_host_end (
  input  wire logic                        REF_CLK,
  input  wire logic                        RST_N,
  mqf_link_if.host                         LINK,
  input  wire logic                        USR_WIDTH_MATCH,
  input  wire logic                        USR_IN_WIDTH,
  input  wire logic                        USR_OUT_WIDTH,
  input  wire logic                        USR_DEFAULT_OFFSET,
  input  wire logic                        USR_PROGRAM_METHOD,
  input  wire logic                        USR_FLAG_MODE,
  input  wire logic                        USR_SINGLE,
  input  wire logic                        USR_RING_RETURN,
  input  wire logic [mqf_pkg::DATA_W-1:0]  USR_WR_DATA,
  input  wire logic                        USR_WR_VALID,
  output logic                             USR_WR_READY,
  input  wire logic                        USR_SEL_VALID,
  input  wire logic [mqf_pkg::ADDR_W-1:0]  USR_SEL_ADDR,
  output logic                             USR_SEL_READY,
  output logic      [mqf_pkg::FLAG_W-1:0]  USR_FLAGS,
  output logic                             USR_FLAGS_VALID,
  output logic                             USR_SYNC,
  output logic                             USR_PROG_DONE
);
  import mqf_pkg::*;

  // ---------------------------------------------------------------------------
  // Straps and token wiring
  // ---------------------------------------------------------------------------
  assign LINK.width_match_strap    = USR_WIDTH_MATCH;
  assign LINK.input_width_strap    = USR_IN_WIDTH;
  assign LINK.output_width_strap   = USR_OUT_WIDTH;
  assign LINK.default_offset_strap = USR_DEFAULT_OFFSET;
  assign LINK.program_method_strap = USR_PROGRAM_METHOD;
  assign LINK.flag_bus_mode_strap  = USR_FLAG_MODE;

  // Direct mode ties the token low; polled mode loops it or closes the ring.
  assign LINK.expansion_token_in = !USR_FLAG_MODE ? 1'b0 :
                                   USR_SINGLE ? LINK.expansion_token_out :
                                   USR_RING_RETURN;

  // ---------------------------------------------------------------------------
  // Data writes
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] wr_mask;
  logic [DATA_W-1:0] data_reg;
  logic              wen_n_reg;

  always_comb begin
    wr_mask = MASK_X36;
    if (USR_WIDTH_MATCH) begin
      wr_mask = USR_IN_WIDTH ? MASK_X9 : MASK_X18;
    end
  end

  assign USR_WR_READY = LINK.full_n;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_reg  <= DATA_RESET;
      wen_n_reg <= 1'b1;
    end else begin
      wen_n_reg <= !(USR_WR_VALID && LINK.full_n);
      if (USR_WR_VALID && LINK.full_n) begin
        data_reg <= USR_WR_DATA & wr_mask;
      end
    end
  end

  assign LINK.data_in    = data_reg;
  assign LINK.write_en_n = wen_n_reg;

  // ---------------------------------------------------------------------------
  // Flag-bus selection and observation
  // ---------------------------------------------------------------------------
  logic              strobe_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [FLAG_W-1:0] flags_reg;
  logic              flags_valid_reg;
  logic              sync_reg;

  assign USR_SEL_READY = !USR_FLAG_MODE && !LINK.serial_program_done_n && !strobe_reg;
  assign USR_PROG_DONE = !LINK.serial_program_done_n;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strobe_reg <= 1'b0;
      addr_reg   <= ADDR_RESET;
    end else begin
      strobe_reg <= USR_SEL_VALID && USR_SEL_READY;
      if (USR_SEL_VALID && USR_SEL_READY) begin
        addr_reg <= USR_SEL_ADDR;
      end
    end
  end

  assign LINK.ae_bus_strobe    = strobe_reg;
  assign LINK.read_address_bus = addr_reg;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_reg       <= FLAGS_RESET;
      flags_valid_reg <= 1'b0;
      sync_reg        <= 1'b0;
    end else begin
      flags_reg       <= LINK.almost_empty_bus;
      flags_valid_reg <= !LINK.almost_empty_bus_oe_n;
      sync_reg        <= LINK.ae_bus_sync;
    end
  end

  assign USR_FLAGS       = flags_reg;
  assign USR_FLAGS_VALID = flags_valid_reg;
  assign USR_SYNC        = sync_reg;

endmodule

`default_nettype wire

// ===== verification/mqf_link_sva.sv
// Purpose: Concurrent checks on the link between the host end and the device end.
// Assumes: One clock domain; the inputs are the link signals of the interface.
// Notes:   Instantiated by the bench beside the interface, without bind.
`default_nettype none

module mqf_link_sva (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic flag_bus_mode_strap,
  input wire logic program_method_strap,
  input wire logic write_en_n,
  input wire logic full_n,
  input wire logic ae_bus_strobe,
  input wire logic almost_empty_bus_oe_n,
  input wire logic ae_bus_sync,
  input wire logic expansion_token_in,
  input wire logic expansion_token_out,
  input wire logic serial_program_done_n
);
  logic [2:0] cnt_reg;

  // ---------------------------------------------------------------------------
  // Cycles since reset release, saturating
  // ---------------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg != 3'h7) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_sync_on_drive: assert property (ae_bus_sync |-> !almost_empty_bus_oe_n && flag_bus_mode_strap)
    else $error("sync high outside a polled drive cycle");
  chk_token_marks_drive: assert property (expansion_token_out |-> !almost_empty_bus_oe_n)
    else $error("token out while the flag bus is released");
  chk_strobe_after_prog: assert property (ae_bus_strobe |-> !serial_program_done_n)
    else $error("strobe before programming finished");
  chk_no_polled_strobe: assert property (flag_bus_mode_strap |-> !ae_bus_strobe)
    else $error("strobe raised in polled mode");
  chk_token_starts_drive: assert property (flag_bus_mode_strap && expansion_token_in
                                           && !serial_program_done_n |=> !almost_empty_bus_oe_n)
    else $error("token received but bus not driven next cycle");
  chk_write_needs_room: assert property (!write_en_n |-> $past(full_n))
    else $error("write issued while full");
  chk_prog_done_holds: assert property (!serial_program_done_n |=> !serial_program_done_n)
    else $error("programming done withdrawn");
  chk_default_prog_time: assert property (cnt_reg == 3'h3 && program_method_strap |-> !serial_program_done_n)
    else $error("default programming not done in time");
  chk_prog_not_early: assert property (cnt_reg <= 3'h2 |-> serial_program_done_n)
    else $error("programming done too early");
  chk_direct_oe_cause: assert property (!flag_bus_mode_strap && $changed(almost_empty_bus_oe_n)
                                        |-> $past(ae_bus_strobe))
    else $error("flag bus enable changed without a strobe");

endmodule

`default_nettype wire

// ===== verification/queue_strap_and_ae_flag_bus_bench.sv
// Purpose: Self-checking bench joining host and device ends over the link.
// Assumes: A single looped device that heads its own ring.
// Notes:   Straps change together with a master reset, except one offset-strap flip in run that must leave the offsets unchanged.
`default_nettype none

module queue_strap_and_ae_flag_bus_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mqf_pkg::*;

  logic        clk;
  logic        rst_n;
  logic [4:0]  st;
  logic [3:0]  ae_st;
  logic        pkt;
  logic        ser_done;
  logic        usr_ready;
  logic [35:0] wr_data;
  logic        wr_valid;
  logic        sel_valid;
  logic [2:0]  sel_addr;
  logic [35:0] u_data;
  logic        u_sop;
  logic        u_eop;
  logic        u_valid;
  logic [7:0]  ae_off;
  logic [7:0]  af_off;
  logic        polled;
  logic [2:0]  wcfg;
  logic        run;
  logic        wr_ready;
  logic        sel_ready;
  logic [3:0]  flags;
  logic        flags_valid;
  logic        single;
  logic        ring_ret;
  logic        h_sync;
  logic        prog_done;
  int          n_fail;
  int          n_compared;

  mqf_link_if i_mqf_link_if ();

  mqf_device_end i_mqf_device_end (
    .REF_CLK(clk), .RST_N(rst_n), .LINK(i_mqf_link_if.device), .USR_AE_STATUS(ae_st), .USR_DEV_ADDR(3'h5),
    .USR_CHAIN_FIRST(1'h1), .USR_PACKET_MODE(pkt), .USR_SERIAL_DONE(ser_done), .USR_DATA(u_data),
    .USR_SOP(u_sop), .USR_EOP(u_eop), .USR_VALID(u_valid), .USR_READY(usr_ready), .USR_AE_OFFSET(ae_off),
    .USR_AF_OFFSET(af_off), .USR_POLLED(polled), .USR_WIDTH_CFG(wcfg), .USR_RUN(run));

  mqf_host_end i_mqf_host_end (
    .REF_CLK(clk), .RST_N(rst_n), .LINK(i_mqf_link_if.host), .USR_WIDTH_MATCH(st[4]), .USR_IN_WIDTH(st[3]),
    .USR_OUT_WIDTH(1'h0), .USR_DEFAULT_OFFSET(st[2]), .USR_PROGRAM_METHOD(st[1]), .USR_FLAG_MODE(st[0]),
    .USR_SINGLE(single), .USR_RING_RETURN(ring_ret), .USR_WR_DATA(wr_data), .USR_WR_VALID(wr_valid),
    .USR_WR_READY(wr_ready), .USR_SEL_VALID(sel_valid), .USR_SEL_ADDR(sel_addr), .USR_SEL_READY(sel_ready),
    .USR_FLAGS(flags), .USR_FLAGS_VALID(flags_valid), .USR_SYNC(h_sync), .USR_PROG_DONE(prog_done));

  mqf_link_sva i_mqf_link_sva (
    .REF_CLK(clk), .RST_N(rst_n), .flag_bus_mode_strap(i_mqf_link_if.flag_bus_mode_strap),
    .program_method_strap(i_mqf_link_if.program_method_strap), .write_en_n(i_mqf_link_if.write_en_n),
    .full_n(i_mqf_link_if.full_n), .ae_bus_strobe(i_mqf_link_if.ae_bus_strobe),
    .almost_empty_bus_oe_n(i_mqf_link_if.almost_empty_bus_oe_n), .ae_bus_sync(i_mqf_link_if.ae_bus_sync),
    .expansion_token_in(i_mqf_link_if.expansion_token_in),
    .expansion_token_out(i_mqf_link_if.expansion_token_out),
    .serial_program_done_n(i_mqf_link_if.serial_program_done_n));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic conclude();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_hi(ref logic sig);
    int k;
    k = 0;
    while (sig !== 1'h1) begin
      k++;
      if (k > 60) begin
        n_fail++;
        $display("MISMATCH at %0t: wait ran out", $time);
        conclude();
      end
      @(negedge clk);
    end
  endtask

  task automatic do_reset(input logic [4:0] s);
    @(negedge clk);
    st = s;
    rst_n = 1'h0;
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    repeat (6) @(negedge clk);
  endtask

  // Valid stays up across words so a burst goes out back to back.
  task automatic push(input logic [35:0] d, input int n);
    wr_valid = 1'h1;
    for (int i = 0; i < n; i++) begin
      wr_data = d + 36'(i);
      wait_hi(wr_ready);
      @(negedge clk);
    end
    wr_valid = 1'h0;
  endtask

  // Ready is left high; the caller lowers it after the last word.
  task automatic pop(input logic [35:0] d);
    wait_hi(u_valid);
    cmp(u_data, d);
    if (pkt) cmp(36'({u_eop, u_sop}), 36'(d[35:34]));
    usr_ready = 1'h1;
    @(negedge clk);
  endtask

  task automatic sel(input logic [2:0] a, input logic hit);
    wait_hi(sel_ready);
    sel_valid = 1'h1;
    sel_addr = a;
    @(negedge clk);
    sel_valid = 1'h0;
    repeat (3) @(negedge clk);
    cmp(36'(i_mqf_link_if.almost_empty_bus_oe_n), 36'(!hit));
    if (hit) cmp(36'({flags_valid, flags}), 36'({1'h1, ae_st}));
  endtask

  // ---------------------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    rst_n = 1'h0;
    st = 5'h00;
    ae_st = 4'h0;
    pkt = 1'h1;
    ser_done = 1'h0;
    usr_ready = 1'h0;
    wr_data = 36'h0_0000_0000;
    wr_valid = 1'h0;
    sel_valid = 1'h0;
    sel_addr = 3'h0;
    single = 1'h1;
    ring_ret = 1'h0;
    // Direct mode, default programming, large offsets, full width.
    do_reset(5'h06);
    cmp(36'({ae_off, af_off}), 36'h0_0000_8080);
    cmp(36'({polled, wcfg, run}), 36'h0_0000_0001);
    cmp(36'({i_mqf_link_if.serial_program_done_n, i_mqf_link_if.expansion_token_in}), 36'h0);
    st[2] = 1'h0;
    repeat (2) @(negedge clk);
    cmp(36'(ae_off), 36'h0_0000_0080);
    push(36'h8_0000_0FF8, 8);
    cmp(36'({wr_ready, i_mqf_link_if.full_n}), 36'h0);
    for (int i = 0; i < 8; i++) begin
      pop(36'h8_0000_0FF8 + 36'(i));
    end
    usr_ready = 1'h0;
    repeat (2) @(negedge clk);
    cmp(36'(u_valid), 36'h0);
    push(36'h4_0000_0001, 1);
    pop(36'h4_0000_0001);
    usr_ready = 1'h0;
    for (int a = 0; a < 8; a++) begin
      ae_st = 4'(a + 3);
      sel(3'(a), a == 5);
    end
    // Polled mode on a looped single device, narrow input width.
    pkt = 1'h0;
    do_reset(5'h1B);
    cmp(36'({ae_off, polled, wcfg}), 36'h0_0000_008E);
    for (int i = 0; i < 6; i++) begin
      ae_st = 4'(i);
      @(negedge clk);
      cmp(36'({i_mqf_link_if.almost_empty_bus_oe_n, i_mqf_link_if.ae_bus_sync, i_mqf_link_if.expansion_token_out,
               i_mqf_link_if.almost_empty_bus}), 36'({3'h3, 4'(i)}));
      cmp(36'({i_mqf_link_if.expansion_token_in, i_mqf_link_if.expansion_token_out, h_sync}), 36'h7);
    end
    // Open the loop, then close the ring through the upstream return.
    single = 1'h0;
    repeat (2) @(negedge clk);
    cmp(36'({i_mqf_link_if.expansion_token_in, i_mqf_link_if.almost_empty_bus_oe_n}), 36'h1);
    ring_ret = 1'h1;
    repeat (2) @(negedge clk);
    cmp(36'({i_mqf_link_if.expansion_token_in, i_mqf_link_if.almost_empty_bus_oe_n}), 36'h2);
    single = 1'h1;
    ring_ret = 1'h0;
    push(36'hF_FFFF_FFFF, 1);
    pop(36'h0_0000_01FF);
    usr_ready = 1'h0;
    // Serial programming: nothing runs until the serial side reports done.
    do_reset(5'h00);
    repeat (10) @(negedge clk);
    cmp(36'({run, sel_ready, i_mqf_link_if.serial_program_done_n, prog_done}), 36'h2);
    ser_done = 1'h1;
    wait_hi(run);
    repeat (2) @(negedge clk);
    cmp(36'({i_mqf_link_if.serial_program_done_n, prog_done, ae_off}), 36'h108);
    ae_st = 4'h9;
    sel(3'h5, 1'h1);
    conclude();
  end

endmodule

`default_nettype wire
